//--- hw/gpp_pin_drv.sv
module gpp_pin_drv
    import gpp_pkg::*;
#(
    parameter int WIDTH = 8
) (
    input  wire logic [WIDTH-1:0] i_latch,
    input  wire logic [WIDTH-1:0] i_push_pull,
    input  wire logic [WIDTH-1:0] i_digital,
    input  wire logic [WIDTH-1:0] i_force_od,
    input  wire logic [WIDTH-1:0] i_pin_in,
    output logic      [WIDTH-1:0] o_pin_out,
    output logic      [WIDTH-1:0] o_pin_oe,
    output logic      [WIDTH-1:0] o_pullup_en,
    output logic      [WIDTH-1:0] o_read_val
);
    always_comb begin
        for (int n = 0; n < WIDTH; n++) begin
            o_pin_out[n]   = i_latch[n];
            // analog pin drives nothing and mode bit is ignored
            o_pin_oe[n]    = i_digital[n] &
                             (~i_latch[n] | (i_push_pull[n] & ~i_force_od[n]));
            o_pullup_en[n] = i_digital[n];
            o_read_val[n]  = i_digital[n] ? i_pin_in[n] : 1'b1;
        end
    end
endmodule : gpp_pin_drv

//--- hw/gpp_pkg.sv
package gpp_pkg;
    typedef logic [7:0] gpp_byte_t;
    typedef enum logic [1:0] {
        GPP_BYTE     = 2'b00,
        GPP_BIT      = 2'b01,
        GPP_RMW_BYTE = 2'b10
    } gpp_acc_t;
endpackage : gpp_pkg

//--- hw/gpp_port.sv
`include "gpp_regs.svh"

module gpp_port
    import gpp_pkg::*;
#(
    parameter int          P1_PINS  = 8,
    parameter logic [7:0]  P1_DRIVE = 8'h00
) (
    input  wire logic       I_CLOCK,
    input  wire logic       I_RESET_N,
    input  wire logic [7:0] I_ADDR,
    input  wire logic       I_WR,
    input  wire logic       I_RD,
    input  wire logic [1:0] I_ACC,
    input  wire logic [2:0] I_BIT_SEL,
    input  wire logic [7:0] I_WDATA,
    output logic      [7:0] O_RDATA,
    input  wire logic [7:0] I_P0_PIN,
    input  wire logic [7:0] I_P1_PIN,
    input  wire logic [7:0] I_XBAR_ASSIGNED0,
    input  wire logic [7:0] I_XBAR_ASSIGNED1,
    input  wire logic [7:0] I_XBAR_OUT0,
    input  wire logic [7:0] I_XBAR_OUT1,
    input  wire logic [7:0] I_TWI_PINS0,
    input  wire logic [7:0] I_TWI_PINS1,
    input  wire logic       I_PULLUP_DIS,
    output logic      [7:0] O_P0_OUT,
    output logic      [7:0] O_P0_OE,
    output logic      [7:0] O_P0_PULLUP,
    output logic      [7:0] O_P1_OUT,
    output logic      [7:0] O_P1_OE,
    output logic      [7:0] O_P1_PULLUP,
    output logic      [7:0] O_P0_SKIP
);
    // ----------------------------------------
    // registers
    // ----------------------------------------
    gpp_byte_t port0_data_q;
    gpp_byte_t port1_data_q;
    gpp_byte_t port0_drive_q;
    gpp_byte_t port0_skip_q;
    gpp_byte_t port0_analog_q;
    gpp_byte_t p1_pin_mask;
    gpp_byte_t p0_rd;
    gpp_byte_t p1_rd;
    gpp_byte_t p0_drv_val;
    gpp_byte_t p1_drv_val;
    gpp_byte_t p0_oe;
    gpp_byte_t p1_oe;
    gpp_byte_t p0_pu;
    gpp_byte_t p1_pu;
    gpp_byte_t rdata_d;

    assign p1_pin_mask = 8'hFF >> (8 - P1_PINS);

    // ----------------------------------------
    // access helpers
    // ----------------------------------------
    // merge a byte or a single bit into the held latch
    function automatic gpp_byte_t merge(input gpp_byte_t cur, input logic [1:0] acc,
                                        input logic [2:0] sel, input gpp_byte_t wd);
        gpp_byte_t r;
        r = cur;
        if (acc == `GPP_ACC_BIT) begin
            r[sel] = wd[0];
        end else begin
            r = wd;
        end
        return r;
    endfunction : merge

    function automatic logic hit(input logic [7:0] a, input logic [7:0] ref_a);
        return a == ref_a;
    endfunction : hit

    // crossbar value wins on assigned pins, latch elsewhere
    function automatic gpp_byte_t pad_value(input gpp_byte_t assigned, input gpp_byte_t periph,
                                            input gpp_byte_t latch);
        return (assigned & periph) | (~assigned & latch);
    endfunction : pad_value

    // rmw sees the latch so untouched bits keep their value; plain reads see the pads
    function automatic gpp_byte_t data_view(input logic [1:0] acc, input gpp_byte_t latch,
                                            input gpp_byte_t pads);
        gpp_byte_t v;
        if (acc == `GPP_ACC_RMW_BYTE) begin
            v = latch;
        end else begin
            v = pads;
        end
        return v;
    endfunction : data_view

    // ----------------------------------------
    // output latches
    // ----------------------------------------
    // a bit write touches one latch bit, so the neighbours keep driving
    always_ff @(posedge I_CLOCK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            port0_data_q <= `GPP_RST_PORT_DATA;
        end else if (I_WR && hit(I_ADDR, `GPP_ADDR_PORT0_DATA)) begin
            port0_data_q <= merge(port0_data_q, I_ACC, I_BIT_SEL, I_WDATA);
        end
    end

    always_ff @(posedge I_CLOCK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            port1_data_q <= `GPP_RST_PORT_DATA;
        end else if (I_WR && hit(I_ADDR, `GPP_ADDR_PORT1_DATA)) begin
            port1_data_q <= merge(port1_data_q, I_ACC, I_BIT_SEL, I_WDATA);
        end
    end

    // ----------------------------------------
    // configuration registers
    // ----------------------------------------
    always_ff @(posedge I_CLOCK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            port0_drive_q <= `GPP_RST_PORT0_DRIVE;
        end else if (I_WR && hit(I_ADDR, `GPP_ADDR_PORT0_DRIVE)) begin
            port0_drive_q <= I_WDATA;
        end
    end

    always_ff @(posedge I_CLOCK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            port0_skip_q <= `GPP_RST_PORT0_SKIP;
        end else if (I_WR && hit(I_ADDR, `GPP_ADDR_PORT0_SKIP)) begin
            port0_skip_q <= I_WDATA;
        end
    end

    always_ff @(posedge I_CLOCK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            port0_analog_q <= `GPP_RST_PORT0_ANALOG;
        end else if (I_WR && hit(I_ADDR, `GPP_ADDR_PORT0_ANALOG)) begin
            port0_analog_q <= I_WDATA;
        end
    end

    // ----------------------------------------
    // crossbar merge
    // ----------------------------------------
    // assigned pins still obey drive mode, analog select and bus open-drain
    assign p0_drv_val = pad_value(I_XBAR_ASSIGNED0, I_XBAR_OUT0, port0_data_q);
    assign p1_drv_val = pad_value(I_XBAR_ASSIGNED1, I_XBAR_OUT1, port1_data_q);

    // ----------------------------------------
    // pin drivers
    // ----------------------------------------
    gpp_pin_drv #(.WIDTH(8)) u_drv0 (
        .i_latch     (p0_drv_val),
        .i_push_pull (port0_drive_q),
        .i_digital   (port0_analog_q),
        .i_force_od  (I_TWI_PINS0),
        .i_pin_in    (I_P0_PIN),
        .o_pin_out   (O_P0_OUT),
        .o_pin_oe    (p0_oe),
        .o_pullup_en (p0_pu),
        .o_read_val  (p0_rd)
    );

    // port1 mode registers are outside this block: all digital, fixed drive
    gpp_pin_drv #(.WIDTH(8)) u_drv1 (
        .i_latch     (p1_drv_val),
        .i_push_pull (P1_DRIVE),
        .i_digital   (8'hFF),
        .i_force_od  (I_TWI_PINS1),
        .i_pin_in    (I_P1_PIN),
        .o_pin_out   (O_P1_OUT),
        .o_pin_oe    (p1_oe),
        .o_pullup_en (p1_pu),
        .o_read_val  (p1_rd)
    );

    // ----------------------------------------
    // pad outputs
    // ----------------------------------------
    // unbonded port1 bits neither drive nor pull, so a loose die pad stays quiet
    assign O_P0_OE     = p0_oe;
    assign O_P1_OE     = p1_oe & p1_pin_mask;
    assign O_P0_PULLUP = p0_pu & {8{~I_PULLUP_DIS}};
    assign O_P1_PULLUP = p1_pu & {8{~I_PULLUP_DIS}} & p1_pin_mask;
    assign O_P0_SKIP   = port0_skip_q;

    // ----------------------------------------
    // read path
    // ----------------------------------------
    // rmw reads see the latch so untouched bits keep their output value
    always_comb begin
        rdata_d = 8'h00;
        case (I_ADDR)
            `GPP_ADDR_PORT0_DATA:   rdata_d = data_view(I_ACC, port0_data_q, p0_rd);
            `GPP_ADDR_PORT1_DATA:   rdata_d = data_view(I_ACC, port1_data_q, p1_rd);
            `GPP_ADDR_PORT0_DRIVE:  rdata_d = port0_drive_q;
            `GPP_ADDR_PORT0_SKIP:   rdata_d = port0_skip_q;
            `GPP_ADDR_PORT0_ANALOG: rdata_d = port0_analog_q;
            default:                rdata_d = 8'h00;
        endcase
        if (I_ACC == `GPP_ACC_BIT) begin
            rdata_d = {7'h00, rdata_d[I_BIT_SEL]};
        end
    end

    always_ff @(posedge I_CLOCK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            O_RDATA <= 8'h00;
        end else if (I_RD) begin
            O_RDATA <= rdata_d;
        end
    end
endmodule : gpp_port

//--- hw/gpp_regs.svh
`ifndef GPP_REGS_SVH
`define GPP_REGS_SVH

// ----------------------------------------
// register addresses
// ----------------------------------------
`define GPP_ADDR_PORT0_DATA     8'h80
`define GPP_ADDR_PORT1_DATA     8'h90
`define GPP_ADDR_PORT0_DRIVE    8'hA4
`define GPP_ADDR_PORT0_SKIP     8'hD4
`define GPP_ADDR_PORT0_ANALOG   8'hF1

// ----------------------------------------
// reset values
// ----------------------------------------
`define GPP_RST_PORT_DATA       8'hFF
`define GPP_RST_PORT0_DRIVE     8'h00
`define GPP_RST_PORT0_SKIP      8'h00
`define GPP_RST_PORT0_ANALOG    8'hFF

// ----------------------------------------
// access kinds
// ----------------------------------------
`define GPP_ACC_BYTE            2'h0
`define GPP_ACC_BIT             2'h1
`define GPP_ACC_RMW_BYTE        2'h2

`endif

//--- tb/gpp_pin_model.sv
module gpp_pin_model (
    input  wire logic [7:0] i_out,
    input  wire logic [7:0] i_oe,
    input  wire logic [7:0] i_pu,
    input  wire logic [7:0] i_ext_en,
    output logic      [7:0] o_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    // strong external pull-down beats the weak pullup; a floating pin shows the inverse
    assign o_pin = (i_oe & i_out) | (~i_oe & ~i_ext_en & (i_pu | ~i_out));
endmodule : gpp_pin_model

//--- tb/gpp_port_asserts.sv
module gpp_port_chk #(
    parameter int P1_PINS = 8
) (
    input wire logic       I_CLOCK,
    input wire logic       I_RESET_N,
    input wire logic       I_WR,
    input wire logic       I_RD,
    input wire logic [1:0] I_ACC,
    input wire logic [7:0] I_ADDR,
    input wire logic [7:0] I_WDATA,
    input wire logic [7:0] O_RDATA,
    input wire logic [7:0] I_P1_PIN,
    input wire logic [7:0] I_XBAR_ASSIGNED0,
    input wire logic [7:0] I_TWI_PINS0,
    input wire logic [7:0] O_P0_OUT,
    input wire logic [7:0] O_P0_OE,
    input wire logic [7:0] O_P0_PULLUP,
    input wire logic [7:0] O_P1_OE,
    input wire logic [7:0] O_P0_SKIP
);
    timeunit 1ns;
    timeprecision 1ps;
    // bits with no bonded pin on the small package
    localparam logic [7:0] NO_PIN = ~(8'hFF >> (8 - P1_PINS));
    default clocking @(posedge I_CLOCK); endclocking
    default disable iff (!I_RESET_N);
    latch_write_a: assert property (
        I_WR && I_ADDR == 8'h80 && I_ACC == 2'h0 |=> ((O_P0_OUT ^ $past(I_WDATA)) & ~I_XBAR_ASSIGNED0) == '0)
        else $error("write lost");
    latch_hold_a: assert property (
        !I_WR && I_XBAR_ASSIGNED0 == '0 ##1 I_XBAR_ASSIGNED0 == '0 |-> $stable(O_P0_OUT)) else $error("drift");
    drive_low_a: assert property ((O_P0_PULLUP & ~O_P0_OUT & ~O_P0_OE) == '0)
        else $error("low not driven");
    twi_od_a: assert property ((I_TWI_PINS0 & O_P0_OUT & O_P0_OE) == '0)
        else $error("bus pin driven");
    pin_read_a: assert property (
        I_RD && I_ADDR == 8'h90 && I_ACC == 2'h0 |=> O_RDATA == $past(I_P1_PIN)) else $error("pin read");
    rmw_read_a: assert property (
        I_RD && I_ADDR == 8'h80 && I_ACC == 2'h2 && I_XBAR_ASSIGNED0 == '0 |=> O_RDATA == $past(O_P0_OUT))
        else $error("rmw read");
    skip_write_a: assert property (
        I_WR && I_ADDR == 8'hD4 && I_ACC == 2'h0 |=> O_P0_SKIP == $past(I_WDATA)) else $error("skip");
    no_pin_a: assert property ((O_P1_OE & NO_PIN) == '0) else $error("unbonded");
endmodule : gpp_port_chk

bind gpp_port gpp_port_chk #(.P1_PINS(P1_PINS)) u_gpp_port_chk (.*);

//--- tb/gpp_port_tb.sv
module gpp_port_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic            clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, pu_off = 1'b0;
    logic [1:0]      acc = 2'h0;
    logic [2:0]      bs = 3'h3;
    logic [7:0]      ad = 8'h00, wd = 8'h00, xa = 8'h00, xo = 8'h00, twi = 8'h00, ext = 8'h00;
    wire logic [7:0] rdata, o0, oe0, pu0, pin0, o1, oe1, pu1, pin1, skip;
    int              num_errors = 0, cmp_count = 0;
    always #5 clk = ~clk;
    gpp_port #(.P1_PINS(6)) u_gpp_port (
        .I_CLOCK(clk), .I_RESET_N(rst_n), .I_ADDR(ad), .I_WR(wr), .I_RD(rd), .I_ACC(acc), .I_BIT_SEL(bs),
        .I_WDATA(wd), .O_RDATA(rdata), .I_P0_PIN(pin0), .I_P1_PIN(pin1), .I_XBAR_ASSIGNED0(xa),
        .I_XBAR_ASSIGNED1(8'h00), .I_XBAR_OUT0(xo), .I_XBAR_OUT1(8'h00), .I_TWI_PINS0(twi), .I_TWI_PINS1(8'h00),
        .I_PULLUP_DIS(pu_off), .O_P0_OUT(o0), .O_P0_OE(oe0), .O_P0_PULLUP(pu0), .O_P1_OUT(o1), .O_P1_OE(oe1),
        .O_P1_PULLUP(pu1), .O_P0_SKIP(skip));
    gpp_pin_model u_gpp_pin_model_0 (.i_out(o0), .i_oe(oe0), .i_pu(pu0), .i_ext_en(8'h00), .o_pin(pin0));
    gpp_pin_model u_gpp_pin_model_1 (.i_out(o1), .i_oe(oe1), .i_pu(pu1), .i_ext_en(ext), .o_pin(pin1));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %0t got %h want %h", $time, seen, exp);
        end
    endtask : chk
    // one bus cycle; for a read d is the expected data
    task automatic bus(input logic w, input logic [7:0] a, input logic [1:0] k, input logic [7:0] d);
        @(posedge clk);
        {wr, rd, ad, acc, wd} <= {w, !w, a, k, d};
        @(posedge clk);
        {wr, rd} <= 2'b00;
        #1;
        if (!w) chk(rdata, d);
    endtask : bus
    task automatic final_report();
        $display("compares %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : final_report
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        chk(oe0, 8'h00);
        chk(o0, 8'hFF);
        bus(0, 8'hA4, 2'h0, 8'h00);
        bus(0, 8'h90, 2'h2, 8'hFF);
        $display("reset test done");
        bus(1, 8'h80, 2'h0, 8'h5A);
        chk(oe0, 8'hA5);
        bus(0, 8'h80, 2'h0, 8'h5A);
        bus(1, 8'hA4, 2'h0, 8'hFF);
        chk(oe0, 8'hFF);
        bus(1, 8'hF1, 2'h0, 8'h0F);
        chk(pu0, 8'h0F);
        bus(0, 8'h80, 2'h0, 8'hFA);
        bus(0, 8'h80, 2'h2, 8'h5A);
        @(posedge clk);
        {twi, xa, xo} <= {8'h03, 8'h04, 8'h04};
        bus(0, 8'h80, 2'h0, 8'hFE);
        chk(oe0, 8'h0D);
        chk(o0, 8'h5E);
        bus(0, 8'h80, 2'h2, 8'h5A);
        $display("port0 test done");
        bus(1, 8'h90, 2'h1, 8'h00);
        bus(0, 8'h90, 2'h2, 8'hF7);
        @(posedge clk);
        bs <= 3'h5;
        bus(1, 8'h90, 2'h1, 8'h00);
        chk(o1, 8'hD7);
        @(posedge clk);
        bs <= 3'h0;
        bus(0, 8'h90, 2'h1, 8'h01);
        @(posedge clk);
        ext <= 8'hFF;
        bus(0, 8'h90, 2'h0, 8'h00);
        bus(1, 8'h90, 2'h0, 8'h00);
        chk(oe1, 8'h3F);
        chk(o1, 8'h00);
        chk(pu1, 8'h3F);
        bus(1, 8'hD4, 2'h0, 8'h81);
        chk(skip, 8'h81);
        bus(0, 8'h55, 2'h0, 8'h00);
        @(posedge clk);
        pu_off <= 1'b1;
        #1;
        chk(pu1, 8'h00);
        $display("port1 test done");
        @(posedge clk);
        rst_n <= 1'b0;
        @(posedge clk);
        rst_n <= 1'b1;
        #1;
        chk(o0, 8'hFF);
        chk(o1, 8'hFF);
        chk(oe0, 8'h00);
        bus(0, 8'hA4, 2'h0, 8'h00);
        $display("second reset test done");
        final_report();
    end
    initial begin
        #20000;
        num_errors++;
        final_report();
    end
endmodule : gpp_port_tb
